// [design/tmf_pkg.sv]
// constants and types shared by the test-mode output forcing block
package tmf_pkg;

    // ********************************************************
    // sizes
    // ********************************************************
    localparam int NUM_OUT = 8;
    localparam int NUM_IN = 8;
    localparam int CODE_W = 3;

    // ********************************************************
    // register byte offsets
    // ********************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OUT_FORCE = 8'h04;
    localparam logic [7:0] OFS_IN_FORCE = 8'h08;
    localparam logic [7:0] OFS_TEST_STAT = 8'h0C;
    localparam logic [7:0] OFS_OUT_STATE = 8'h10;
    localparam logic [7:0] OFS_IN_STATE = 8'h14;
    localparam logic [7:0] OFS_OUT_CODE = 8'h18;

    // ********************************************************
    // control field positions and reset values
    // ********************************************************
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam int CTRL_LATCH_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [15:0] FORCE_RST = 16'h0000;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_REQ_BIT = 1;

    // outputs with voltage/current supervision; the rest are changeover types
    localparam logic [NUM_OUT-1:0] SUPERVISED_MASK = 8'h0F;

    // ********************************************************
    // force settings, two bits per contact
    // ********************************************************
    typedef enum logic [1:0] {
        OUT_FOLLOW,
        OUT_ENERGIZE,
        OUT_DEENERGIZE,
        OUT_FREEZE
    } tmf_out_force_e;

    typedef enum logic [1:0] {
        IN_LIVE,
        IN_FORCE_OPEN,
        IN_FORCE_CLOSED,
        IN_LIVE_ALT
    } tmf_in_force_e;

    // ********************************************************
    // reported state codes
    // ********************************************************
    localparam logic [CODE_W-1:0] CODE_OFF = 3'h0;
    localparam logic [CODE_W-1:0] CODE_VOLTAGE_DETECTOR_OFF = 3'h1;
    localparam logic [CODE_W-1:0] CODE_CURRENT_DETECTOR_OFF = 3'h2;
    localparam logic [CODE_W-1:0] CODE_ON = 3'h3;
    localparam logic [CODE_W-1:0] CODE_VOLTAGE_DETECTOR_ON = 3'h4;
    localparam logic [CODE_W-1:0] CODE_CURRENT_DETECTOR_ON = 3'h5;

endpackage

// [design/tmf_status_code.sv]
// encodes each contact output's reported state, with detector qualifiers for supervised outputs only
module tmf_status_code
    import tmf_pkg::*;
(
    // contact state and detectors
    input wire logic [NUM_OUT-1:0] out_state,
    input wire logic [NUM_OUT-1:0] voltage_detect,
    input wire logic [NUM_OUT-1:0] current_detect,
    // encoded state, CODE_W bits per output
    output logic [NUM_OUT*CODE_W-1:0] out_code
);

    // ********************************************************
    // encoding
    // ********************************************************
    // current flow outranks voltage presence: it is the stronger evidence
    function automatic logic [CODE_W-1:0] state_code(
        input logic on,
        input logic sup,
        input logic vdet,
        input logic idet
    );
        logic [CODE_W-1:0] c;
        c = on ? CODE_ON : CODE_OFF;
        if (sup && idet) begin
            c = on ? CODE_CURRENT_DETECTOR_ON : CODE_CURRENT_DETECTOR_OFF;
        end else if (sup && vdet) begin
            c = on ? CODE_VOLTAGE_DETECTOR_ON : CODE_VOLTAGE_DETECTOR_OFF;
        end
        return c;
    endfunction

    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            out_code[i*CODE_W +: CODE_W] = state_code(out_state[i], SUPERVISED_MASK[i],
                voltage_detect[i], current_detect[i]); // [RL6] [RL7]
        end
    end

endmodule

// [design/tmf_test_force.sv]
// test-mode forcing of contact outputs and inputs, with apb registers
//
// Notes on behaviour
// [RL1] forcing disabled: output closes on operand 1, opens on operand 0.
// [RL2] energize: output closed throughout test mode, operand ignored.
// [RL3] de-energize: output open throughout test mode, operand ignored.
// [RL4] freeze: output holds its pre-test state until test mode ends.
// [RL5] latching initiate: first press starts test, next press ends it.
// [RL6] reported state: On is logic 1, Off is logic 0.
// [RL7] supervised outputs report detector qualifiers; changeover ones only Off/On.
// [RL8] test mode begins only when enabled and initiate is logic 1.
// [RL9] forced inputs report 0 when open, 1 when closed, during test.
// [RL10] after test ends outputs follow their operands on next clock.
module tmf_test_force
    import tmf_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // internal control operands and test initiate
    input wire logic [NUM_OUT-1:0] control_operand,
    input wire logic initiate_operand,
    // contact inputs and output detectors
    input wire logic [NUM_IN-1:0] contact_input_raw,
    input wire logic [NUM_OUT-1:0] voltage_detect,
    input wire logic [NUM_OUT-1:0] current_detect,
    // contact drivers and reported states
    output logic [NUM_OUT-1:0] contact_drive,
    output logic [NUM_IN-1:0] input_report,
    output logic test_active
);

    // ********************************************************
    // apb slave and settings registers
    // ********************************************************
    logic [2:0] ctrl;
    logic [15:0] output_force_select;
    logic [15:0] input_force_select;
    logic test_req;
    logic init_prev;
    logic [NUM_OUT-1:0] frozen;
    logic [NUM_OUT*CODE_W-1:0] out_code;
    logic [2:0] next_ctrl;
    logic [15:0] next_out_force;
    logic [15:0] next_in_force;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic wr_en;

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == OFS_CTRL) || (a == OFS_OUT_FORCE) || (a == OFS_IN_FORCE) ||
            (a == OFS_TEST_STAT) || (a == OFS_OUT_STATE) || (a == OFS_IN_STATE) ||
            (a == OFS_OUT_CODE);
    endfunction

    // write lands at the access edge only
    assign wr_en = psel && penable && pready && pwrite;

    always_comb begin
        next_ctrl = ctrl;
        next_out_force = output_force_select;
        next_in_force = input_force_select;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        // setup cycle prepares the answer so every apb output is a flop
        if (psel && !penable) begin
            next_pready = 1'b1;
            next_pslverr = !addr_mapped(paddr);
            next_prdata = 32'h0000_0000;
            case (paddr)
                OFS_CTRL: next_prdata[2:0] = ctrl;
                OFS_OUT_FORCE: next_prdata[15:0] = output_force_select;
                OFS_IN_FORCE: next_prdata[15:0] = input_force_select;
                OFS_TEST_STAT: begin
                    next_prdata[STAT_ACTIVE_BIT] = test_active;
                    next_prdata[STAT_REQ_BIT] = test_req;
                end
                OFS_OUT_STATE: next_prdata[NUM_OUT-1:0] = contact_drive; // [RL6]
                OFS_IN_STATE: next_prdata[NUM_IN-1:0] = input_report;
                OFS_OUT_CODE: next_prdata[NUM_OUT*CODE_W-1:0] = out_code; // [RL7]
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        if (wr_en && !pslverr) begin
            case (paddr)
                OFS_CTRL: next_ctrl = pwdata[2:0];
                OFS_OUT_FORCE: next_out_force = pwdata[15:0];
                OFS_IN_FORCE: next_in_force = pwdata[15:0];
                default: next_ctrl = ctrl;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RST;
            output_force_select <= FORCE_RST;
            input_force_select <= FORCE_RST;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            output_force_select <= next_out_force;
            input_force_select <= next_in_force;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ********************************************************
    // test request and test mode
    // ********************************************************
    logic next_test_req;
    logic next_init_prev;
    logic next_test;
    logic latch_state;
    logic next_latch_state;

    always_comb begin
        next_init_prev = initiate_operand;
        next_latch_state = latch_state;
        next_test_req = test_req;
        if (!ctrl[CTRL_SRC_BIT]) begin
            // initiate set to a fixed on
            next_test_req = 1'b1;
        end else if (ctrl[CTRL_LATCH_BIT]) begin
            // the toggle keeps its own state: a request left by the fixed or level
            // source must not start a latched test before the first press
            if (initiate_operand && !init_prev) begin
                next_latch_state = !latch_state; // [RL5]
            end
            next_test_req = next_latch_state; // [RL5]
        end else begin
            next_test_req = initiate_operand;
        end
        next_test = ctrl[CTRL_ENABLE_BIT] && next_test_req; // [RL8]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_req <= 1'b0;
            init_prev <= 1'b0;
            latch_state <= 1'b0;
            test_active <= 1'b0;
        end else begin
            test_req <= next_test_req;
            init_prev <= next_init_prev;
            latch_state <= next_latch_state;
            test_active <= next_test;
        end
    end

    // ********************************************************
    // contact output forcing
    // ********************************************************
    logic [NUM_OUT-1:0] next_drive;
    logic [NUM_OUT-1:0] next_frozen;

    always_comb begin
        next_drive = control_operand; // [RL1] [RL10]
        next_frozen = frozen;
        // capture on entry; the value is the drive from before the test
        if (next_test && !test_active) begin
            next_frozen = contact_drive; // [RL4]
        end
        for (int i = 0; i < NUM_OUT; i++) begin
            if (next_test) begin
                case (tmf_out_force_e'(output_force_select[2*i +: 2]))
                    OUT_FOLLOW: next_drive[i] = control_operand[i]; // [RL1]
                    OUT_ENERGIZE: next_drive[i] = 1'b1; // [RL2]
                    OUT_DEENERGIZE: next_drive[i] = 1'b0; // [RL3]
                    OUT_FREEZE: next_drive[i] = next_frozen[i]; // [RL4]
                    default: next_drive[i] = control_operand[i];
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            contact_drive <= '0;
            frozen <= '0;
        end else begin
            contact_drive <= next_drive;
            frozen <= next_frozen;
        end
    end

    // ********************************************************
    // contact input forcing
    // ********************************************************
    logic [NUM_IN-1:0] next_input_report;

    always_comb begin
        next_input_report = contact_input_raw;
        for (int i = 0; i < NUM_IN; i++) begin
            if (next_test) begin
                case (tmf_in_force_e'(input_force_select[2*i +: 2]))
                    IN_FORCE_OPEN: next_input_report[i] = 1'b0; // [RL9]
                    IN_FORCE_CLOSED: next_input_report[i] = 1'b1; // [RL9]
                    default: next_input_report[i] = contact_input_raw[i];
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_report <= '0;
        end else begin
            input_report <= next_input_report;
        end
    end

    // ********************************************************
    // reported state encoding
    // ********************************************************
    tmf_status_code u_status_code (
        .out_state(contact_drive),
        .voltage_detect(voltage_detect),
        .current_detect(current_detect),
        .out_code(out_code)
    );

    // ********************************************************
    // checks
    // ********************************************************
    a_test_entry: assert property ( // [RL8]
        @(posedge pclk) disable iff (!presetn)
        $rose(test_active) |-> $past(ctrl[CTRL_ENABLE_BIT]) && $past(next_test_req))
        else $error("test mode entered without enable and initiate");

    a_test_gate: assert property ( // [RL8]
        @(posedge pclk) disable iff (!presetn)
        test_active |-> $past(ctrl[CTRL_ENABLE_BIT]))
        else $error("test mode active while the function was disabled");

    a_latch_toggle: assert property ( // [RL5]
        @(posedge pclk) disable iff (!presetn)
        (ctrl[CTRL_SRC_BIT] && ctrl[CTRL_LATCH_BIT] && initiate_operand && !init_prev)
        |=> test_req == !$past(latch_state))
        else $error("latched initiate press did not toggle the request");

    a_exit_follow: assert property ( // [RL10]
        @(posedge pclk) disable iff (!presetn)
        $fell(test_active) |-> contact_drive == $past(control_operand))
        else $error("outputs did not follow operands after test end");

    genvar g;
    for (g = 0; g < NUM_OUT; g++) begin : g_out_chk
        a_follow_op: assert property ( // [RL1]
            @(posedge pclk) disable iff (!presetn)
            (output_force_select[2*g +: 2] == OUT_FOLLOW)
            |=> contact_drive[g] == $past(control_operand[g]))
            else $error("unforced output did not track its operand");

        a_energize_hold: assert property ( // [RL2]
            @(posedge pclk) disable iff (!presetn)
            (next_test && output_force_select[2*g +: 2] == OUT_ENERGIZE)
            |=> contact_drive[g])
            else $error("energized output not closed during test");

        a_deenergize_hold: assert property ( // [RL3]
            @(posedge pclk) disable iff (!presetn)
            (next_test && output_force_select[2*g +: 2] == OUT_DEENERGIZE)
            |=> !contact_drive[g])
            else $error("de-energized output not open during test");

        a_freeze_hold: assert property ( // [RL4]
            @(posedge pclk) disable iff (!presetn)
            (next_test && output_force_select[2*g +: 2] == OUT_FREEZE
                && $stable(output_force_select))
            |=> contact_drive[g] == $past(contact_drive[g]))
            else $error("frozen output changed during test");

        a_code_onoff: assert property ( // [RL6] [RL7]
            @(posedge pclk) disable iff (!presetn)
            contact_drive[g] == (out_code[g*CODE_W +: CODE_W] >= CODE_ON)
            && (SUPERVISED_MASK[g] || out_code[g*CODE_W +: CODE_W] == CODE_ON
                || out_code[g*CODE_W +: CODE_W] == CODE_OFF))
            else $error("reported output code disagrees with contact state");
    end

    for (g = 0; g < NUM_IN; g++) begin : g_in_chk
        a_input_forced: assert property ( // [RL9]
            @(posedge pclk) disable iff (!presetn)
            (next_test && input_force_select[2*g +: 2] == IN_FORCE_OPEN)
            |=> !input_report[g])
            else $error("forced-open input did not report 0");

        a_input_closed: assert property ( // [RL9]
            @(posedge pclk) disable iff (!presetn)
            (next_test && input_force_select[2*g +: 2] == IN_FORCE_CLOSED)
            |=> input_report[g])
            else $error("forced-closed input did not report 1");
    end

endmodule

// [tb/tmf_ext_circuit.sv]
// model of the external circuits wired to the contact outputs
module tmf_ext_circuit
    import tmf_pkg::*;
(
    // contact drivers from the block
    input wire logic [NUM_OUT-1:0] contact_drive,
    // scenario controls: supply wired, load wired, leakage fault
    input wire logic [NUM_OUT-1:0] supply_on,
    input wire logic [NUM_OUT-1:0] load_on,
    input wire logic [NUM_OUT-1:0] leak_on,
    // detector feedback to the block
    output logic [NUM_OUT-1:0] voltage_detect,
    output logic [NUM_OUT-1:0] current_detect
);
    timeunit 1ns;
    timeprecision 1ns;
    // voltage is seen whenever the supply is wired, open or closed
    assign voltage_detect = supply_on;
    // current needs a load and either a closed contact or a commanded leak path
    assign current_detect = load_on & (contact_drive | leak_on);
endmodule

// [tb/test_tmf_test_force.sv]
// self-checking testbench for the test-mode output forcing block
module test_tmf_test_force
    import tmf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic initiate_operand = 1'h0;
    logic [7:0] paddr = 8'h00, control_operand = 8'h00, contact_input_raw = 8'h00;
    logic [7:0] supply_on = 8'h00, load_on = 8'h00, leak_on = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, test_active;
    logic [7:0] voltage_detect, current_detect, contact_drive, input_report;
    int fails = 0, n_checks = 0;

    always #25 pclk = ~pclk;

    tmf_test_force uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .control_operand(control_operand),
        .initiate_operand(initiate_operand), .contact_input_raw(contact_input_raw),
        .voltage_detect(voltage_detect), .current_detect(current_detect),
        .contact_drive(contact_drive), .input_report(input_report),
        .test_active(test_active));

    tmf_ext_circuit ext (.contact_drive(contact_drive), .supply_on(supply_on),
        .load_on(load_on), .leak_on(leak_on), .voltage_detect(voltage_detect),
        .current_detect(current_detect));

    // ********************************************************
    // shared tasks
    // ********************************************************
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; waits for pready without assuming a latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (pready !== 1'h1) begin
            fails++;
            $display("BAD pready expected 1 seen timeout");
            results();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 32'h0000_0000, r, e);
        chk(name, exp, r);
        chk("pslverr", 32'h0000_0000, {31'h0, e});
    endtask

    task automatic settle;
        @(posedge pclk);
        #1;
    endtask

    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
    endtask

    task automatic press;
        @(posedge pclk);
        initiate_operand <= 1'h1;
        @(posedge pclk);
        initiate_operand <= 1'h0;
        settle();
    endtask

    function automatic logic [2:0] code_of(input logic on, v, i, sup);
        if (!sup) return on ? CODE_ON : CODE_OFF;
        if (on) return i ? CODE_CURRENT_DETECTOR_ON : (v ? CODE_VOLTAGE_DETECTOR_ON : CODE_ON);
        return i ? CODE_CURRENT_DETECTOR_OFF : (v ? CODE_VOLTAGE_DETECTOR_OFF : CODE_OFF);
    endfunction

    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rd_chk("ctrl", OFS_CTRL, 32'h0000_0000);
        rd_chk("out_force", OFS_OUT_FORCE, 32'h0000_0000);
        rd_chk("in_force", OFS_IN_FORCE, 32'h0000_0000);
        apb(1'h0, 8'h1C, 32'h0000_0000, r, e);
        chk("pslverr", 32'h0000_0001, {31'h0, e});
        chk("unmapped data", 32'h0000_0000, r);
        // writes to read-only and unmapped offsets must leave every setting alone
        wr(OFS_TEST_STAT, 32'hFFFF_FFFF);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd_chk("read-only status", OFS_TEST_STAT, 32'h0000_0002);
        rd_chk("ctrl kept", OFS_CTRL, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_follow;
        logic [7:0] v[3] = '{8'h00, 8'hFF, 8'h5A};
        foreach (v[i]) begin
            @(posedge pclk);
            control_operand <= v[i];
            settle();
            chk("contact_drive", {24'h0, v[i]}, {24'h0, contact_drive});
        end
        $display("test follow done");
    endtask

    // out0 freeze, out1 de-energize, out2 energize, out3 follow
    // in1 open, in2 closed, in3 live by the alternate code; raw levels oppose the forcing
    task automatic t_force;
        wr(OFS_OUT_FORCE, 32'h0000_001B);
        wr(OFS_IN_FORCE, 32'h0000_00E4);
        wr(OFS_CTRL, 32'h0000_0003);
        @(posedge pclk);
        control_operand <= 8'h01;
        contact_input_raw <= 8'hFB;
        settle();
        chk("idle test_active", 32'h0, {31'h0, test_active});
        @(posedge pclk);
        initiate_operand <= 1'h1;
        settle();
        chk("test_active", 32'h1, {31'h0, test_active});
        @(posedge pclk);
        control_operand <= 8'hFA;
        settle();
        chk("forced drive", 32'h0000_00FD, {24'h0, contact_drive});
        chk("forced inputs", 32'h0000_00FD, {24'h0, input_report});
        rd_chk("status", OFS_TEST_STAT, 32'h0000_0003);
        rd_chk("drive reg", OFS_OUT_STATE, 32'h0000_00FD);
        @(posedge pclk);
        initiate_operand <= 1'h0;
        settle();
        chk("end test_active", 32'h0, {31'h0, test_active});
        chk("released drive", 32'h0000_00FA, {24'h0, contact_drive});
        chk("released inputs", 32'h0000_00FB, {24'h0, input_report});
        $display("test force done");
    endtask

    task automatic t_latch;
        do_reset();
        wr(OFS_CTRL, 32'h0000_0007);
        settle();
        chk("latch idle", 32'h0, {31'h0, test_active});
        press();
        settle();
        chk("latch first", 32'h1, {31'h0, test_active});
        press();
        settle();
        chk("latch second", 32'h0, {31'h0, test_active});
        wr(OFS_CTRL, 32'h0000_0001);
        settle();
        chk("fixed on", 32'h1, {31'h0, test_active});
        wr(OFS_CTRL, 32'h0000_0000);
        settle();
        chk("disabled", 32'h0, {31'h0, test_active});
        $display("test latch done");
    endtask

    task automatic t_codes;
        logic [7:0] sv[2] = '{8'hFF, 8'h00};
        logic [7:0] ld[2] = '{8'h0C, 8'h00};
        logic [7:0] lk[2] = '{8'h08, 8'h00};
        logic [31:0] exp;
        @(posedge pclk);
        control_operand <= 8'hA5;
        foreach (sv[p]) begin
            @(posedge pclk);
            supply_on <= sv[p];
            load_on <= ld[p];
            leak_on <= lk[p];
            settle();
            exp = 32'h0000_0000;
            for (int i = 0; i < NUM_OUT; i++) begin
                exp[i*3 +: 3] = code_of(control_operand[i], sv[p][i],
                    ld[p][i] & (control_operand[i] | lk[p][i]), SUPERVISED_MASK[i]);
            end
            rd_chk("codes", OFS_OUT_CODE, exp);
        end
        $display("test codes done");
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_follow();
        t_force();
        t_latch();
        t_codes();
        results();
    end
endmodule
